//--- rtl/ifeb_bank.sv
// Interrupt request flag and enable bank for four 8-bit registers.
// Assumes APB from the core and event pulses from peripherals on clk_sys.
// Functional notes
// - Ctrl two: bit7 group0 flag, bit3 enable
// - Ctrl two: bit6 pin B flag, bit2 enable
// - Ctrl two: bits5,4 overvolt6/5 flags, bits1,0 enables
// - Ctrl three: bits7-4 group4..1 flags
// - Ctrl three: bits3-0 group4..1 enables
// - Multi zero: bit7 converter flag, bit3 enable
// - Multi zero: bit6 timebase0 flag, bit2 enable
// - Multi zero: bit5 duty flag, bit1 enable
// - Multi zero: bit4 period flag, bit0 enable
// - Multi one: bits7,6 overvolt1/0 flags, bits3,2 enables
// - Multi one: bit5 timer A flag, bit1 enable
// - Multi one: bit4 timer P flag, bit0 enable
// - Event sets flag regardless of enable
// - Interrupt taken only if flag and enable
// - Global enable zero blocks srcIrqReq and coreIrq; irq still follows masked status
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module ifeb_bank
	import ifeb_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Control-two sources
	input wire logic group0Event,
	input wire logic extPinBEvent,
	input wire logic overvolt6Event,
	input wire logic overvolt5Event,
	// Control-three sources
	input wire logic group4Event,
	input wire logic group3Event,
	input wire logic group2Event,
	input wire logic group1Event,
	// Multi-zero sources
	input wire logic converterDoneEvent,
	input wire logic timebaseZeroEvent,
	input wire logic dutyMatchEvent,
	input wire logic periodMatchEvent,
	// Multi-one sources
	input wire logic overvolt1Event,
	input wire logic overvolt0Event,
	input wire logic periodicTimerAEvent,
	input wire logic periodicTimerPEvent,
	// Requests to the core
	output logic [15:0] srcIrqReq,
	output logic coreIrq,
	output logic irq
);
	// ==========================================================
	// Bus decode
	logic apbWrite; // Write access completes
	logic apbRead; // Read access completes
	logic hitCtrlTwo, hitCtrlThree, hitMultiZero, hitMultiOne;
	logic hitGlobal, hitStatus, hitMask;
	logic hitAny; // Address is mapped
	logic lane0; // Byte lane 0 written
	assign apbWrite = psel & penable & pwrite;
	assign apbRead = psel & penable & ~pwrite;
	assign hitCtrlTwo = (paddr == IFEB_OFF_CTRL_TWO);
	assign hitCtrlThree = (paddr == IFEB_OFF_CTRL_THREE);
	assign hitMultiZero = (paddr == IFEB_OFF_MULTI_ZERO);
	assign hitMultiOne = (paddr == IFEB_OFF_MULTI_ONE);
	assign hitGlobal = (paddr == IFEB_OFF_GLOBAL);
	assign hitStatus = (paddr == IFEB_OFF_STATUS);
	assign hitMask = (paddr == IFEB_OFF_MASK);
	assign hitAny = hitCtrlTwo | hitCtrlThree | hitMultiZero | hitMultiOne | hitGlobal | hitStatus | hitMask;
	// Registers are one byte wide, so only lane 0 carries data
	assign lane0 = pstrb[0];

	// Zero wait states; unmapped address answers with an error
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hitAny;

	// ==========================================================
	// Slices: the event nibble maps bit 3 to flag bit 7 down to bit 0 to flag bit 4
	ifeb_nib_if nibs [IFEB_NREG] ();
	logic [3:0] evtNib [IFEB_NREG]; // Events per register
	logic [IFEB_NREG-1:0] regHit; // Address hit per register
	logic [7:0] regVal [IFEB_NREG]; // Register read values
	assign evtNib[IFEB_R_CTRL_TWO] = {group0Event, extPinBEvent, overvolt6Event, overvolt5Event};
	assign evtNib[IFEB_R_CTRL_THREE] = {group4Event, group3Event, group2Event, group1Event};
	assign evtNib[IFEB_R_MULTI_ZERO] = {converterDoneEvent, timebaseZeroEvent, dutyMatchEvent,
		periodMatchEvent};
	assign evtNib[IFEB_R_MULTI_ONE] = {overvolt1Event, overvolt0Event, periodicTimerAEvent,
		periodicTimerPEvent};
	assign regHit = {hitMultiOne, hitMultiZero, hitCtrlThree, hitCtrlTwo};

	genvar gi;
	generate
		for (gi = 0; gi < IFEB_NREG; gi++) begin : gSlice
			// Write strobe and data into each slice
			assign nibs[gi].wrEn = apbWrite & regHit[gi] & lane0;
			assign nibs[gi].wrData = pwdata[7:0];
			assign nibs[gi].events = evtNib[gi];
			assign regVal[gi] = nibs[gi].regValue;
			ifeb_slice uSlice (
				.clk_sys(clk_sys),
				.resetn(resetn),
				.nib(nibs[gi])
			);
		end
	endgenerate

	// ==========================================================
	// Global enable, held in its own register
	logic globalIrqEnable_q; // Global interrupt enable
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			globalIrqEnable_q <= 1'b0;
		end else if (apbWrite & hitGlobal & lane0) begin
			globalIrqEnable_q <= pwdata[0];
		end
	end

	// ==========================================================
	// Per-source requests: flag and enable together
	logic [15:0] flagsAll; // All request flags
	logic [15:0] enablesAll; // All enables
	logic [15:0] srcReq; // Flag and enable per source
	assign flagsAll = {regVal[3][7:4], regVal[2][7:4], regVal[1][7:4], regVal[0][7:4]};
	assign enablesAll = {regVal[3][3:0], regVal[2][3:0], regVal[1][3:0], regVal[0][3:0]};
	assign srcReq = flagsAll & enablesAll;
	// Gated by the global enable so the core never sees a blocked source
	assign srcIrqReq = globalIrqEnable_q ? srcReq : 16'h0000;
	assign coreIrq = |srcIrqReq;

	// ==========================================================
	// Event status: request rising edge and bad bus access
	logic coreIrqPrev_q; // Previous core request level
	logic [1:0] evtStat_q, evtStat_d; // Sticky status
	logic [1:0] evtMask_q; // Interrupt mask
	logic [1:0] evtSet; // New events
	logic [1:0] evtClr; // Write-one-to-clear
	assign evtSet = {pslverr, coreIrq & ~coreIrqPrev_q};
	assign evtClr = (apbWrite & hitStatus & lane0) ? pwdata[1:0] : IFEB_ST_RESET;
	// Set wins over a clear in the same cycle
	assign evtStat_d = (evtStat_q & ~evtClr) | evtSet;
	assign irq = |(evtStat_q & evtMask_q);

	// Status, mask and edge history
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			evtStat_q <= IFEB_ST_RESET;
			evtMask_q <= IFEB_ST_RESET;
			coreIrqPrev_q <= 1'b0;
		end else begin
			evtStat_q <= evtStat_d;
			coreIrqPrev_q <= coreIrq;
			if (apbWrite & hitMask & lane0) begin
				evtMask_q <= pwdata[1:0];
			end
		end
	end

	// ==========================================================
	// Read mux; upper bits read as zero
	logic [31:0] rdMux; // Selected read word
	assign rdMux = hitCtrlTwo ? {24'h000000, regVal[IFEB_R_CTRL_TWO]} :
		hitCtrlThree ? {24'h000000, regVal[IFEB_R_CTRL_THREE]} :
		hitMultiZero ? {24'h000000, regVal[IFEB_R_MULTI_ZERO]} :
		hitMultiOne ? {24'h000000, regVal[IFEB_R_MULTI_ONE]} :
		hitGlobal ? {31'h00000000, globalIrqEnable_q} :
		hitStatus ? {30'h00000000, evtStat_q} :
		hitMask ? {30'h00000000, evtMask_q} : IFEB_ZERO32;
	// Read data are sampled in the setup cycle so they stand through the access
	logic [31:0] rdata_q;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= IFEB_ZERO32;
		end else if (psel & ~penable & ~pwrite) begin
			rdata_q <= rdMux;
		end
	end
	// Zero outside a read access
	assign prdata = apbRead ? rdata_q : IFEB_ZERO32;
endmodule : ifeb_bank

//--- rtl/ifeb_nib_if.sv
// Interface between the bank top and one four-source register slice.
// Assumes the slice and the top share clk_sys.
`timescale 1ns/1ps
interface ifeb_nib_if;
	// Bus write strobe and data for this slice
	logic wrEn;
	logic [7:0] wrData;
	// Source events and register value
	logic [3:0] events;
	logic [7:0] regValue;
	// Top side drives writes and events
	modport top (output wrEn, output wrData, output events, input regValue);
	// Slice side keeps flags and enables
	modport slice (input wrEn, input wrData, input events, output regValue);
endinterface : ifeb_nib_if

//--- rtl/ifeb_pkg.sv
// Constants and types shared by the interrupt flag and enable bank.
// Assumes a 32-bit APB master and one 100 MHz system clock.
package ifeb_pkg;
	// ==========================================================
	// Register byte offsets
	localparam logic [11:0] IFEB_OFF_CTRL_TWO = 12'h000;
	localparam logic [11:0] IFEB_OFF_CTRL_THREE = 12'h004;
	localparam logic [11:0] IFEB_OFF_MULTI_ZERO = 12'h008;
	localparam logic [11:0] IFEB_OFF_MULTI_ONE = 12'h00C;
	localparam logic [11:0] IFEB_OFF_GLOBAL = 12'h010;
	localparam logic [11:0] IFEB_OFF_STATUS = 12'h014;
	localparam logic [11:0] IFEB_OFF_MASK = 12'h018;
	// ==========================================================
	// Field layout of the four flag and enable registers
	localparam int IFEB_FLAG_LSB = 4;
	localparam int IFEB_NIB = 4;
	localparam int IFEB_NREG = 4;
	localparam int IFEB_NSRC = 16;
	localparam logic [7:0] IFEB_REG_RESET = 8'h00;
	localparam logic [3:0] IFEB_NIB_RESET = 4'h0;
	// Bank indices
	localparam int IFEB_R_CTRL_TWO = 0;
	localparam int IFEB_R_CTRL_THREE = 1;
	localparam int IFEB_R_MULTI_ZERO = 2;
	localparam int IFEB_R_MULTI_ONE = 3;
	// ==========================================================
	// Event status bits
	localparam int IFEB_ST_REQ = 0;
	localparam int IFEB_ST_ERR = 1;
	localparam logic [1:0] IFEB_ST_RESET = 2'h0;
	localparam logic [31:0] IFEB_ZERO32 = 32'h00000000;
endpackage : ifeb_pkg

//--- rtl/ifeb_slice.sv
// One 8-bit request and enable register: flags high, enables low.
// Assumes events are one-cycle pulses or levels on clk_sys.
`timescale 1ns/1ps
module ifeb_slice
	import ifeb_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// Register access
	ifeb_nib_if.slice nib
);
	// ==========================================================
	// Storage
	logic [3:0] flag_q, flag_d; // Request flags
	logic [3:0] enable_q; // Enables

	// Software write sets value; a hardware event always wins
	assign flag_d = (nib.wrEn ? nib.wrData[IFEB_FLAG_LSB +: IFEB_NIB] : flag_q) | nib.events;
	assign nib.regValue = {flag_q, enable_q};

	// ==========================================================
	// Flag and enable registers
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			flag_q <= IFEB_NIB_RESET;
			enable_q <= IFEB_NIB_RESET;
		end else begin
			flag_q <= flag_d;
			// Enables change only by software
			if (nib.wrEn) begin
				enable_q <= nib.wrData[IFEB_NIB-1:0];
			end
		end
	end
endmodule : ifeb_slice

//--- testbench/ifeb_bank_assertions.sv
// Port-level checks for the interrupt flag and enable bank.
// Assumes it is bound to the bank top and sees only its ports.
`timescale 1ns/1ps
module ifeb_bank_assertions (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Sources and requests
	input wire logic group0Event,
	input wire logic [15:0] srcIrqReq,
	input wire logic coreIrq
);
	// ====================
	// Access phase decode, shared by the checks
	wire acc = psel && penable;
	wire wrAcc = acc && pwrite;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	property p_ready; acc |-> pready; endproperty
	a_ready: assert property (p_ready) else $error("pready low in access phase");
	property p_unmapped; acc && paddr > 12'h018 |-> pslverr && prdata == 32'h00000000; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
	property p_mapped; acc && paddr <= 12'h018 && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
	a_mapped: assert property (p_mapped) else $error("mapped access refused");
	property p_err_acc; pslverr |-> acc; endproperty
	a_err_acc: assert property (p_err_acc) else $error("pslverr outside access phase");
	property p_rd_idle; !(acc && !pwrite) |-> prdata == 32'h00000000; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("prdata not zero outside read");
	property p_core_or; coreIrq == (srcIrqReq != 16'h0000); endproperty
	a_core_or: assert property (p_core_or) else $error("coreIrq not the OR of requests");
	// A request can only appear after its event or a register write
	property p_src_rise; $rose(srcIrqReq[3]) |-> $past(group0Event) || $past(wrAcc); endproperty
	a_src_rise: assert property (p_src_rise) else $error("request rose without cause");
	// Flags and enables are only cleared by software
	property p_src_fall; $fell(srcIrqReq[3]) |-> $past(wrAcc); endproperty
	a_src_fall: assert property (p_src_fall) else $error("request fell without a write");
endmodule : ifeb_bank_assertions

//--- testbench/ifeb_bank_tb.sv
// Self-checking bench for the interrupt flag and enable bank.
// Assumes a zero-wait APB slave and the source model beside it.
`timescale 1ns/1ps
module ifeb_bank_tb;
	import ifeb_pkg::*;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata, rdData;
	logic pready, pslverr, coreIrq, irq, errSeen;
	logic [15:0] ev, srcIrqReq;
	int num_errors = 0;
	int cmp_count = 0;
	always #5 clk_sys = ~clk_sys;
	// ====================
	// Device and event sources; lane 0 strobe always on
	ifeb_bank uut (.clk_sys, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF),
		.prdata, .pready, .pslverr, .group0Event(ev[3]), .extPinBEvent(ev[2]), .overvolt6Event(ev[1]),
		.overvolt5Event(ev[0]), .group4Event(ev[7]), .group3Event(ev[6]), .group2Event(ev[5]),
		.group1Event(ev[4]), .converterDoneEvent(ev[11]), .timebaseZeroEvent(ev[10]),
		.dutyMatchEvent(ev[9]), .periodMatchEvent(ev[8]), .overvolt1Event(ev[15]),
		.overvolt0Event(ev[14]), .periodicTimerAEvent(ev[13]), .periodicTimerPEvent(ev[12]),
		.srcIrqReq, .coreIrq, .irq);
	ifeb_src_model src (.clk_sys, .events(ev));
	// ====================
	// Compare, bus and verdict tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Setup then access; holds everything until pready is sampled high at a rising edge
	// Data and error are taken at that same edge; one idle edge follows so a
	// second call never re-raises psel in the time step that lowered it
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rdData = prdata;
		errSeen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(a, 1'b0, 32'h00000000);
		chk(rdData, exp);
	endtask : rd
	// Requests, core line and irq looked at mid-cycle, once settled
	task automatic irqChk(input logic [15:0] e, input logic i);
		@(negedge clk_sys);
		chk({14'h0000, irq, coreIrq, srcIrqReq}, {14'h0000, i, |e, e});
		@(posedge clk_sys);
	endtask : irqChk
	task automatic print_verdict;
		if (num_errors == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : print_verdict
	initial begin
		#100000;
		num_errors++;
		print_verdict();
	end
	// ====================
	// Main sequence
	initial begin
		repeat (3) @(posedge clk_sys);
		resetn <= 1'b1;
		@(posedge clk_sys);
		for (int r = 0; r < 4; r++) rd(12'(4 * r), 32'h00000000);
		apb(IFEB_OFF_GLOBAL, 1'b1, 32'h00000001);
		for (int r = 0; r < 4; r++) begin
			for (int j = 0; j < 4; j++) begin
				src.pulse(4 * r + j);
				rd(12'(4 * r), 32'h10 << j);
				irqChk(16'h0000, 1'b0);
				apb(12'(4 * r), 1'b1, 32'h11 << j);
				irqChk(16'h0001 << (4 * r + j), 1'b0);
				apb(12'(4 * r), 1'b1, 32'h00000000);
			end
		end
		apb(IFEB_OFF_MULTI_ONE, 1'b1, 32'h000000FF);
		rd(IFEB_OFF_MULTI_ONE, 32'h000000FF);
		apb(IFEB_OFF_GLOBAL, 1'b1, 32'h00000000);
		irqChk(16'h0000, 1'b0);
		apb(IFEB_OFF_MULTI_ONE, 1'b1, 32'h00000000);
		rd(IFEB_OFF_MULTI_ONE, 32'h00000000);
		apb(IFEB_OFF_STATUS, 1'b1, 32'h00000003);
		apb(IFEB_OFF_MASK, 1'b1, 32'h00000003);
		apb(IFEB_OFF_GLOBAL, 1'b1, 32'h00000001);
		apb(IFEB_OFF_MULTI_ONE, 1'b1, 32'h00000011);
		rd(IFEB_OFF_STATUS, 32'h00000001);
		irqChk(16'h1000, 1'b1);
		apb(IFEB_OFF_STATUS, 1'b1, 32'h00000001);
		irqChk(16'h1000, 1'b0);
		rd(12'h020, 32'h00000000);
		chk({31'h0, errSeen}, 32'h00000001);
		rd(IFEB_OFF_STATUS, 32'h00000002);
		irqChk(16'h1000, 1'b1);
		apb(IFEB_OFF_MASK, 1'b1, 32'h00000000);
		irqChk(16'h1000, 1'b0);
		print_verdict();
	end
endmodule : ifeb_bank_tb
bind ifeb_bank ifeb_bank_assertions chk_i (.clk_sys, .resetn, .psel, .penable, .pwrite, .paddr,
	.prdata, .pready, .pslverr, .group0Event, .srcIrqReq, .coreIrq);

//--- testbench/ifeb_src_model.sv
// Behavioural peripheral event sources for the bank.
// Assumes callers enter pulse just after a rising clk_sys edge.
`timescale 1ns/1ps
module ifeb_src_model (
	// Clock
	input wire logic clk_sys,
	// One event line per source
	output logic [15:0] events
);
	initial events = 16'h0000;
	// One-cycle event, as a peripheral match or completion gives
	task automatic pulse(input int idx);
		events <= 16'(16'h0001 << idx);
		@(posedge clk_sys);
		events <= 16'h0000;
	endtask : pulse
endmodule : ifeb_src_model
